// *** cgi_pkg.sv ***
// shared constants for the clock generator i2c link
package cgi_pkg;
  localparam logic [6:0] CGI_BUS_SLAVE_ADDRESS = 7'h69;
  localparam logic [7:0] CGI_PTR_RESET = 8'h00;
  localparam int CGI_CLK_MHZ = 250;
  localparam int CGI_MAX_KBPS = 400;
  // cycles of i_ref_clk per quarter of the fastest legal scl period
  localparam int CGI_QUARTER_CYC =
    (CGI_CLK_MHZ * 1000 + 4 * CGI_MAX_KBPS - 1) / (4 * CGI_MAX_KBPS);
  localparam int CGI_FIFO_DEPTH = 16;
  localparam int CGI_REG_COUNT = 256;
  localparam logic [7:0] CGI_REG_DEFAULT = 8'h00;
  localparam int CGI_FIFO_ENTRY_W = 17;
  localparam logic [1:0] CGI_OP_WRITE = 2'h0;
  localparam logic [1:0] CGI_OP_READ = 2'h1;
  localparam logic [1:0] CGI_OP_SETPTR = 2'h2;
endpackage : cgi_pkg

// *** cgi_fifo.sv ***
// parameterised valid/ready fifo
`timescale 1ns/100ps
module cgi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } cgi_fifo_state_type;
  cgi_fifo_state_type st_r, st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic full, empty, push, pop;
  // one extra pointer bit tells full from empty
  assign empty = st_r.wp == st_r.rp;
  assign full = (st_r.wp[AW] != st_r.rp[AW]) &&
                (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_r[st_r.rp[AW-1:0]];
  assign push = i_in_valid && !full && i_ce;
  assign pop = i_out_ready && !empty && i_ce;
  // pointer advance
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
  // storage has no reset, only written slots are read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[st_r.wp[AW-1:0]] <= i_in_data;
    end
  end
endmodule : cgi_fifo

// *** cgi_link_if.sv ***
// two-wire bus between master and slave ends
`timescale 1ns/100ps
interface cgi_link_if;
  logic scl_o, scl_oe;
  logic m_sda_o, m_sda_oe;
  logic s_sda_o, s_sda_oe;
  logic scl, sda;
  // open drain: any enabled driver with a low output pulls the wire low
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : cgi_link_if

// *** cgi_slave.sv ***
// i2c register slave end of the clock generator
`timescale 1ns/100ps
module cgi_slave
  import cgi_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  cgi_link_if.slave bus,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_stb,
  output logic [7:0] o_pointer,
  output logic o_busy
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RECV = 6'h02,
    S_ACK = 6'h04,
    S_SEND = 6'h08,
    S_MACK = 6'h10,
    S_IGNORE = 6'h20
  } cgi_slv_fsm_type;
  typedef struct packed {
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d;
    cgi_slv_fsm_type fsm;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [1:0] byten;
    logic rd;
    logic drive_low;
    logic [7:0] ptr;
    logic [7:0] wa, wd;
    logic wstb;
  } cgi_slv_state_type;
  cgi_slv_state_type st_r, st_nxt;
  logic [7:0] regs_r [CGI_REG_COUNT];
  logic scl, sda, scl_rise, scl_fall, start, stop;
  logic [7:0] rd_byte;
  // second synchroniser stage feeds all logic
  assign scl = st_r.scl_s[1];
  assign sda = st_r.sda_s[1];
  assign scl_rise = scl && !st_r.scl_d;
  assign scl_fall = !scl && st_r.scl_d;
  assign start = scl && st_r.scl_d && st_r.sda_d && !sda;
  assign stop = scl && st_r.scl_d && !st_r.sda_d && sda;
  assign rd_byte = regs_r[st_r.ptr];
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = st_r.drive_low;
  assign o_wr_addr = st_r.wa;
  assign o_wr_data = st_r.wd;
  assign o_wr_stb = st_r.wstb;
  assign o_pointer = st_r.ptr;
  assign o_busy = st_r.fsm != S_IDLE && st_r.fsm != S_IGNORE;
  // bit engine; sampling on scl rise relies on master keeping
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_s = {st_r.scl_s[0], bus.scl};
    st_nxt.sda_s = {st_r.sda_s[0], bus.sda};
    st_nxt.scl_d = scl;
    st_nxt.sda_d = sda;
    st_nxt.wstb = 1'b0;
    if (start) begin
      st_nxt.fsm = S_RECV;
      st_nxt.bitn = 4'h0;
      st_nxt.byten = 2'h0;
      st_nxt.drive_low = 1'b0;
    end else if (stop) begin
      st_nxt.fsm = S_IDLE;
      st_nxt.drive_low = 1'b0;
    end else begin
      unique case (st_r.fsm)
        S_IDLE, S_IGNORE: begin
          st_nxt.drive_low = 1'b0;
        end
        S_RECV: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda};
            st_nxt.bitn = st_r.bitn + 4'h1;
          end
          if (scl_fall && st_r.bitn == 4'h8) begin
            st_nxt.bitn = 4'h0;
            if (st_r.byten == 2'h0) begin
              if (st_r.shift[7:1] == CGI_BUS_SLAVE_ADDRESS) begin
                st_nxt.rd = st_r.shift[0];
                st_nxt.fsm = S_ACK;
                st_nxt.drive_low = 1'b1;
                st_nxt.byten = 2'h1;
              end else begin
                st_nxt.fsm = S_IGNORE;
              end
            end else if (st_r.byten == 2'h1) begin
              st_nxt.ptr = st_r.shift;
              st_nxt.fsm = S_ACK;
              st_nxt.drive_low = 1'b1;
              st_nxt.byten = 2'h2;
            end else begin
              st_nxt.wa = st_r.ptr;
              st_nxt.wd = st_r.shift;
              st_nxt.wstb = 1'b1;
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.fsm = S_ACK;
              st_nxt.drive_low = 1'b1;
            end
          end
        end
        S_ACK: begin
          // after the ninth clock falls: release on writes, or on reads drive the first data bit
          if (scl_fall) begin
            if (st_r.rd) begin
              st_nxt.fsm = S_SEND;
              st_nxt.shift = rd_byte;
              st_nxt.drive_low = !rd_byte[7];
              st_nxt.bitn = 4'h1;
            end else begin
              st_nxt.fsm = S_RECV;
              st_nxt.drive_low = 1'b0;
            end
          end
        end
        S_SEND: begin
          // new bit only while scl low
          if (scl_fall) begin
            if (st_r.bitn == 4'h8) begin
              st_nxt.fsm = S_MACK;
              st_nxt.drive_low = 1'b0;
              st_nxt.ptr = st_r.ptr + 8'h01;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.drive_low = !st_r.shift[6];
              st_nxt.bitn = st_r.bitn + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            st_nxt.shift = {7'h00, sda};
          end
          if (scl_fall) begin
            if (!st_r.shift[0]) begin
              st_nxt.fsm = S_SEND;
              st_nxt.shift = rd_byte;
              st_nxt.drive_low = !rd_byte[7];
              st_nxt.bitn = 4'h1;
            end else begin
              st_nxt.fsm = S_IGNORE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0;
      st_r.scl_s <= 2'h3;
      st_r.sda_s <= 2'h3;
      st_r.scl_d <= 1'b1;
      st_r.sda_d <= 1'b1;
      st_r.fsm <= S_IDLE;
      st_r.ptr <= CGI_PTR_RESET;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
  // register bank, defaults on reset, contents lost at power off
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (int i = 0; i < CGI_REG_COUNT; i++) begin
        regs_r[i] <= CGI_REG_DEFAULT;
      end
    end else if (i_ce && st_nxt.wstb) begin
      regs_r[st_r.ptr] <= st_r.shift;
    end
  end
endmodule : cgi_slave

// *** cgi_master.sv ***
// i2c master end: runs queued commands on the two-wire bus
`timescale 1ns/100ps
module cgi_master
  import cgi_pkg::*;
#(
  parameter int QUARTER = CGI_QUARTER_CYC,
  parameter int DEPTH = CGI_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  cgi_link_if.master bus,
  // cmd: op[16:15], last[14], unused[13:8] reserved zero, data[7:0]
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [CGI_FIFO_ENTRY_W-1:0] i_cmd,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_nack,
  output logic o_busy
);
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_START = 4'h2,
    M_BIT = 4'h4,
    M_STOP = 4'h8
  } cgi_mst_fsm_type;
  typedef struct packed {
    cgi_mst_fsm_type fsm;
    logic [15:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [7:0] rx;
    logic [1:0] seg;
    logic [CGI_FIFO_ENTRY_W-1:0] cmd;
    logic scl_low, sda_low;
    logic [1:0] sda_s;
    logic rdv, nack;
  } cgi_mst_state_type;
  cgi_mst_state_type st_r, st_nxt;
  logic q_valid, q_take;
  logic [CGI_FIFO_ENTRY_W-1:0] q_data;
  logic tick, burst_next;
  // back-pressure: commands wait here while the bus is slow
  cgi_fifo #(.WIDTH(CGI_FIFO_ENTRY_W), .DEPTH(DEPTH)) u_q (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_in_valid(i_cmd_valid), .o_in_ready(o_cmd_ready), .i_in_data(i_cmd),
    .o_out_valid(q_valid), .i_out_ready(q_take), .o_out_data(q_data));
  assign tick = st_r.cnt == 16'(QUARTER - 1);
  // a frame in flight takes its next byte only after an acked byte
  assign burst_next = st_r.fsm == M_BIT && tick && st_r.ph == 2'h3 &&
                      st_r.bitn == 4'h8 && st_r.seg != 2'h0 &&
                      !st_r.nack && !st_r.cmd[14];
  assign q_take = q_valid && (st_r.fsm == M_IDLE || burst_next);
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = st_r.scl_low;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = st_r.sda_low;
  assign o_rd_data = st_r.rx;
  assign o_rd_valid = st_r.rdv;
  assign o_nack = st_r.nack;
  assign o_busy = st_r.fsm != M_IDLE;
  // seg: 0 address byte, 1 data out, 2 data in
  always_comb begin
    st_nxt = st_r;
    st_nxt.sda_s = {st_r.sda_s[0], bus.sda};
    st_nxt.rdv = 1'b0;
    st_nxt.cnt = tick ? 16'h0000 : st_r.cnt + 16'h0001;
    unique case (st_r.fsm)
      M_IDLE: begin
        st_nxt.cnt = 16'h0000;
        if (q_valid) begin
          st_nxt.cmd = q_data;
          st_nxt.fsm = M_START;
          st_nxt.ph = 2'h0;
          st_nxt.nack = 1'b0;
        end
      end
      M_START: begin
        // release both, then pull sda low with scl high
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          if (st_r.ph == 2'h0) begin
            st_nxt.sda_low = 1'b0;
          end else if (st_r.ph == 2'h1) begin
            st_nxt.scl_low = 1'b0;
          end else if (st_r.ph == 2'h2) begin
            st_nxt.sda_low = 1'b1;
          end else begin
            st_nxt.scl_low = 1'b1;
            st_nxt.fsm = M_BIT;
            st_nxt.bitn = 4'h0;
            st_nxt.seg = 2'h0;
            st_nxt.tx = {CGI_BUS_SLAVE_ADDRESS,
                         st_r.cmd[16:15] == CGI_OP_READ, 1'b1};
          end
        end
      end
      M_BIT: begin
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          if (st_r.ph == 2'h0) begin
            st_nxt.sda_low = !st_r.tx[8];
          end else if (st_r.ph == 2'h1) begin
            st_nxt.scl_low = 1'b0;
          end else if (st_r.ph == 2'h2) begin
            // the ninth bit is the ack, kept out of the data byte
            if (st_r.bitn != 4'h8) begin
              st_nxt.rx = {st_r.rx[6:0], st_r.sda_s[1]};
            end
            if (st_r.bitn == 4'h8 && st_r.seg != 2'h2 && st_r.sda_s[1]) begin
              st_nxt.nack = 1'b1;
            end
          end else begin
            st_nxt.scl_low = 1'b1;
            st_nxt.tx = {st_r.tx[7:0], 1'b1};
            st_nxt.bitn = st_r.bitn + 4'h1;
            if (st_r.bitn == 4'h7 && st_r.seg == 2'h2) begin
              // master drives the ack on reads, nack on the last byte
              st_nxt.tx = {st_r.cmd[14], 8'hFF};
            end
            if (st_r.bitn == 4'h8) begin
              st_nxt.bitn = 4'h0;
              if (st_r.seg == 2'h2) begin
                st_nxt.rx = st_r.rx;
                st_nxt.rdv = 1'b1;
              end
              if (st_r.nack || (st_r.seg != 2'h0 && st_r.cmd[14])) begin
                st_nxt.fsm = M_STOP;
              end else if (st_r.seg == 2'h0) begin
                st_nxt.seg = st_r.cmd[16:15] == CGI_OP_READ ? 2'h2 : 2'h1;
                // a read leaves sda to the slave
                st_nxt.tx = st_r.cmd[16:15] == CGI_OP_READ ? 9'h1FF :
                            {st_r.cmd[7:0], 1'b1};
              end else if (q_valid) begin
                // the next queued command carries on the frame
                st_nxt.cmd = q_data;
                st_nxt.tx = st_r.seg == 2'h2 ? 9'h1FF : {q_data[7:0], 1'b1};
              end else if (st_r.seg == 2'h1) begin
                st_nxt.fsm = M_STOP;
              end else begin
                // read already acked: slave sends one more, then nack
                st_nxt.cmd[14] = 1'b1;
              end
            end
          end
        end
      end
      M_STOP: begin
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          if (st_r.ph == 2'h0) begin
            st_nxt.sda_low = 1'b1;
          end else if (st_r.ph == 2'h1) begin
            st_nxt.scl_low = 1'b0;
          end else if (st_r.ph == 2'h2) begin
            st_nxt.sda_low = 1'b0;
          end else begin
            st_nxt.fsm = M_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0;
      st_r.fsm <= M_IDLE;
      st_r.sda_s <= 2'h3;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
endmodule : cgi_master

// *** cgi_link_asserts.sv ***
// concurrent checks on the two-wire link between master and slave ends
`timescale 1ns/100ps
module cgi_link_asserts
  import cgi_pkg::*;
#(
  parameter int QUARTER = CGI_QUARTER_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [15:0] gap_r;
  logic scl_q_r;

  // cycles since the last scl rise, saturating so idle gaps never wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      gap_r <= 16'hFFFF;
      scl_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      if (scl && !scl_q_r) gap_r <= 16'h0001;
      else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  AST_SCL_RATE: assert property (
    scl && !scl_q_r |-> gap_r >= 16'(4 * QUARTER))
    else $error("scl period shorter than four quarters");
  AST_IDLE_AFTER_RST: assert property (disable iff (1'b0)
    i_srst |=> scl && sda) else $error("bus not released by reset");
  AST_SLV_LOW_ONLY: assert property (
    $rose(s_sda_oe) |-> !scl && !s_sda_o)
    else $error("slave starts pulling sda while scl high");
  AST_SLV_DATA_STABLE: assert property (
    $past(scl) && scl |-> $stable(s_sda_oe))
    else $error("slave moved sda while scl high");
  AST_ACK_HOLD: assert property (
    scl && !scl_q_r && s_sda_oe |-> s_sda_oe [*4])
    else $error("slave low level not held through scl high");
  AST_START_SILENT: assert property ($fell(sda) && scl && $past(scl)
    |-> !s_sda_oe [*8]) else $error("slave drives sda right after start");
  AST_STOP_RELEASE: assert property ($rose(sda) && scl && $past(scl)
    |-> !s_sda_oe [*8]) else $error("slave drives sda after stop");
  AST_NO_FIGHT: assert property (
    s_sda_oe && scl |-> !(m_sda_oe && !m_sda_o))
    else $error("master pulls sda while slave drives");

  // main scenarios seen on the wire
  cover property ($fell(sda) && scl && $past(scl));
  cover property ($rose(sda) && scl && $past(scl));
  cover property (scl && !scl_q_r && s_sda_oe);
endmodule : cgi_link_asserts

// *** clock_gen_i2c_register_slave_tb_top.sv ***
// self-checking bench: master and slave ends joined over the link
`timescale 1ns/100ps
module clock_gen_i2c_register_slave_tb_top;
  import cgi_pkg::*;
  localparam int QUARTER = 4; // short quarter keeps the run brief
  logic i_ref_clk;
  logic i_srst;
  logic cmd_valid;
  logic [CGI_FIFO_ENTRY_W-1:0] cmd;
  logic cmd_ready, rd_valid, m_nack, m_busy, wr_stb, s_busy;
  logic [7:0] rd_data, wr_addr, wr_data, pointer, sh;
  logic [7:0] rq[$];
  logic [15:0] wq[$];
  logic [7:0] aq[$];
  int bad_count = 0;
  int num_checks = 0;
  int bc = 99;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic saw_full;
  logic ce;

  cgi_link_if link();
  cgi_master #(.QUARTER(QUARTER), .DEPTH(CGI_FIFO_DEPTH)) cgi_master_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(ce),
    .bus(link.master), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd(cmd), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_nack(m_nack), .o_busy(m_busy));
  cgi_slave cgi_slave_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(ce), .bus(link.slave),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_wr_stb(wr_stb),
    .o_pointer(pointer), .o_busy(s_busy));
  cgi_link_asserts #(.QUARTER(QUARTER)) cgi_link_asserts_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl),
    .sda(link.sda));

  // collect slave writes, read bytes and the first byte of each frame
  always @(posedge i_ref_clk) begin
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (sda_q && !link.sda && link.scl) bc = 0;
    else if (!scl_q && link.scl) begin
      sh = {sh[6:0], link.sda}; // msb arrives first
      bc++;
      if (bc == 8) aq.push_back(sh);
    end
    scl_q = link.scl;
    sda_q = link.sda;
  end

  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // hold the command until the edge that sees ready high
  task automatic send(input logic [1:0] op, input logic last,
      input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd <= {op, last, 6'h00, d};
    do begin
      @(negedge i_ref_clk);
      if (cmd_ready !== 1'b1) saw_full = 1'b1;
    end while (cmd_ready !== 1'b1);
    @(posedge i_ref_clk);
  endtask : send

  // bounded wait for the expected bytes and both ends idle
  task automatic settle(input int nr, input int nw);
    int n;
    n = 0;
    cmd_valid <= 1'b0;
    while ((rq.size() < nr || wq.size() < nw || m_busy !== 1'b0 ||
        s_busy !== 1'b0) && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n == 20000) check("settle time", 16'h0000, 16'h0001);
    repeat (4) @(posedge i_ref_clk);
  endtask : settle

  task automatic t_defaults();
    send(CGI_OP_READ, 1'b1, 8'h00);
    settle(1, 0);
    check("default byte", 16'h0000, {8'h00, rq.pop_front()});
    check("pointer", 16'h0001, {8'h00, pointer});
    check("frame addr", {8'h00, CGI_BUS_SLAVE_ADDRESS, 1'b1},
      {8'h00, aq.pop_front()});
    check("nack", 16'h0000, {15'h0000, m_nack});
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_burst();
    saw_full = 1'b0;
    send(CGI_OP_WRITE, 1'b0, 8'hF8);
    // one byte more than the fifo holds forces back-pressure
    for (int i = 0; i < 17; i++) begin
      send(CGI_OP_WRITE, i == 16, 8'hA0 + 8'(i));
    end
    settle(0, 17);
    check("fifo full seen", 16'h0001, {15'h0000, saw_full});
    check("frame addr", {8'h00, CGI_BUS_SLAVE_ADDRESS, 1'b0},
      {8'h00, aq.pop_front()});
    for (int i = 0; i < 17; i++) begin
      check("write", {8'hF8 + 8'(i), 8'hA0 + 8'(i)},
        wq.pop_front());
    end
    check("nack", 16'h0000, {15'h0000, m_nack});
    check("pointer", 16'h0009, {8'h00, pointer});
    $display("test burst write done");
  endtask : t_burst

  task automatic t_random();
    send(CGI_OP_WRITE, 1'b1, 8'hFE);
    for (int i = 0; i < 4; i++) begin
      send(CGI_OP_READ, i == 3, 8'h00);
    end
    settle(4, 0);
    for (int i = 0; i < 4; i++) begin
      check("seq read", {8'h00, 8'hA6 + 8'(i)},
        {8'h00, rq.pop_front()});
    end
    check("no store", 16'h0000, 16'(wq.size()));
    check("pointer", 16'h0002, {8'h00, pointer});
    $display("test random read done");
  endtask : t_random

  task automatic t_current();
    logic s0;
    logic moved;
    moved = 1'b0;
    send(CGI_OP_READ, 1'b1, 8'h00);
    cmd_valid <= 1'b0;
    // freeze both ends mid-frame; the read must still finish intact
    repeat (40) @(posedge i_ref_clk);
    ce <= 1'b0;
    @(posedge i_ref_clk);
    s0 = link.scl;
    repeat (24) begin
      @(posedge i_ref_clk);
      if (link.scl !== s0) moved = 1'b1;
    end
    check("scl frozen", 16'h0000, {15'h0000, moved});
    ce <= 1'b1;
    settle(1, 0);
    check("current read", 16'h00AA, {8'h00, rq.pop_front()});
    check("pointer", 16'h0003, {8'h00, pointer});
    $display("test current read done");
  endtask : t_current

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // free-running reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // reset, then the scenarios in order
  initial begin
    i_srst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    ce = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    t_defaults();
    t_burst();
    t_random();
    t_current();
    results();
  end

  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : clock_gen_i2c_register_slave_tb_top
